//--- src/prf_rx_formatter.sv
// receive pin formatter: word buffer, crossing to the link clock, per-mode pin mapping
`timescale 1ns/100ps
`include "prf_regs.svh"
module prf_rx_formatter
  import prf_pkg::*;
#(
  parameter logic [5:0] DIV_1000 = `PRF_DIV_1000,
  parameter logic [5:0] DIV_100 = `PRF_DIV_100,
  parameter logic [5:0] DIV_10 = `PRF_DIV_10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire prf_mode_t mode,
  input wire logic tbi_two_clock_select,
  input wire logic clock_direction_select,
  input wire prf_word_t in_data,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] rxd_i,
  output logic [7:0] rxd_o,
  output logic [7:0] rxd_oe_n,
  input wire logic rx_dv_i,
  output logic rx_dv_o,
  output logic rx_dv_oe_n,
  input wire logic rx_er_i,
  output logic rx_er_o,
  output logic rx_er_oe_n,
  input wire logic rx_clk_i,
  output logic rx_clk_o,
  output logic rx_clk_oe_n,
  output logic secondary_receive_clock,
  output logic secondary_receive_clock_oe_n,
  output prf_word_t strap_cfg
);

  // ---------------- system clock side ----------------
  prf_word_t pin_s1_reg;
  prf_word_t pin_s2_reg;
  prf_word_t strap_reg;
  logic [4:0] cfg_reg;
  prf_word_t buf_data;
  logic buf_valid;
  logic xfer_busy_reg;
  logic req_tog_reg;
  prf_word_t hold_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;

  always_ff @(posedge clk) begin
    pin_s1_reg <= {rx_er_i, rx_dv_i, rxd_i};
    pin_s2_reg <= pin_s1_reg;
  end

  // the pins read as straps for as long as reset lasts; the last sample wins
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_reg <= pin_s2_reg;
    end
  end

  assign strap_cfg = strap_reg;

  // mode inputs are taken as static; change them only while reset is held
  always_ff @(posedge clk) begin
    cfg_reg <= {clock_direction_select, tbi_two_clock_select | strap_reg[`PRF_W_DV], mode};
  end

  prf_buf #(
    .W(`PRF_WORD_W),
    .DEPTH(`PRF_BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(!xfer_busy_reg)
  );

  logic ack_tog_reg;

  always_ff @(posedge clk) begin
    ack_s1_reg <= ack_tog_reg;
    ack_s2_reg <= ack_s1_reg;
  end

  // toggle handshake: hold_reg stays put until the link side has echoed the toggle
  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_busy_reg <= 1'b0;
      req_tog_reg <= 1'b0;
      hold_reg <= `PRF_IDLE_WORD;
    end else if (!xfer_busy_reg && buf_valid) begin
      hold_reg <= buf_data;
      req_tog_reg <= !req_tog_reg;
      xfer_busy_reg <= 1'b1;
    end else if (xfer_busy_reg && ack_s2_reg == req_tog_reg) begin
      xfer_busy_reg <= 1'b0;
    end
  end

  // ---------------- link clock side ----------------
  logic lrst_s1_reg;
  logic lrst_reg;
  logic [4:0] cfg_s1_reg;
  logic [4:0] cfg_s2_reg;
  logic req_s1_reg;
  logic req_s2_reg;
  logic [2:0] rclk_sync_reg;
  prf_mode_t lmode;
  logic two_clk;
  logic ext_clk;
  logic tbi2;
  logic mii;
  logic rgmii;
  logic er_hiz_mode;
  logic [5:0] div;
  logic [5:0] cnt_reg;
  logic [1:0] ph_reg;
  logic [1:0] ph_next;
  logic half_tick;
  logic rise_ev;
  logic fall_ev;
  logic load_ev;
  prf_word_t pend_reg;
  logic pend_valid_reg;
  prf_word_t cur_reg;
  prf_word_t cur_next;

  always_ff @(posedge link_clk) begin
    lrst_s1_reg <= rst;
    lrst_reg <= lrst_s1_reg;
    cfg_s1_reg <= cfg_reg;
    cfg_s2_reg <= cfg_s1_reg;
    req_s1_reg <= req_tog_reg;
    req_s2_reg <= req_s1_reg;
    rclk_sync_reg <= {rclk_sync_reg[1:0], rx_clk_i};
  end

  assign lmode = prf_mode_t'(cfg_s2_reg[`PRF_CFG_MODE]);
  assign two_clk = cfg_s2_reg[`PRF_CFG_TWO];
  assign mii = (lmode == PRF_MII10) || (lmode == PRF_MII100);
  assign rgmii = (lmode == PRF_RGMII10) || (lmode == PRF_RGMII100) || (lmode == PRF_RGMII1000);
  assign er_hiz_mode = rgmii || (lmode == PRF_RTBI);
  assign tbi2 = (lmode == PRF_TBI) && two_clk;
  assign ext_clk = cfg_s2_reg[`PRF_CFG_DIR] && mii;

  always_comb begin
    case (lmode)
      PRF_MII10, PRF_RGMII10: div = DIV_10;
      PRF_MII100, PRF_RGMII100: div = DIV_100;
      default: div = DIV_1000;
    endcase
  end

  // half-period divider; the pin clock toggles on every half_tick, or on every second one in two-clock TBI
  assign half_tick = cnt_reg >= div - 6'h01;
  assign ph_next = ph_reg + 2'h1;

  always_ff @(posedge link_clk) begin
    if (lrst_reg || half_tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      ph_reg <= 2'h0;
    end else if (half_tick) begin
      ph_reg <= ph_next;
    end
  end

  // an outside clock is seen through two flops, so edges lag the pin by 2-3 cycles
  assign rise_ev = ext_clk ? (rclk_sync_reg[1] && !rclk_sync_reg[2]) : (half_tick && !ph_reg[0]);
  assign fall_ev = ext_clk ? (!rclk_sync_reg[1] && rclk_sync_reg[2]) : (half_tick && ph_reg[0]);
  // two-clock groups launch where the primary or the secondary clock rises
  assign load_ev = tbi2 ? fall_ev : rise_ev;

  // an empty slot at launch time sends the idle word rather than stalling the pins
  assign cur_next = pend_valid_reg ? pend_reg : `PRF_IDLE_WORD;

  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      pend_valid_reg <= 1'b0;
      pend_reg <= `PRF_IDLE_WORD;
      ack_tog_reg <= 1'b0;
    end else begin
      if (load_ev) begin
        pend_valid_reg <= 1'b0;
      end
      if (req_s2_reg != ack_tog_reg && (!pend_valid_reg || load_ev)) begin
        pend_reg <= hold_reg;
        pend_valid_reg <= 1'b1;
        ack_tog_reg <= req_s2_reg;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      cur_reg <= `PRF_IDLE_WORD;
    end else if (load_ev) begin
      cur_reg <= cur_next;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      rx_clk_o <= 1'b0;
      rx_clk_oe_n <= 1'b1;
      secondary_receive_clock <= 1'b0;
      secondary_receive_clock_oe_n <= 1'b1;
    end else begin
      rx_clk_oe_n <= ext_clk;
      secondary_receive_clock_oe_n <= !tbi2;
      if (half_tick) begin
        if (tbi2) begin
          rx_clk_o <= ph_next[1];
          secondary_receive_clock <= !ph_next[1];
        end else begin
          rx_clk_o <= !ph_reg[0];
        end
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst_reg) begin
      rxd_o <= '0;
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
      rxd_oe_n <= `PRF_OE_ALL_OFF;
      rx_dv_oe_n <= 1'b1;
      rx_er_oe_n <= 1'b1;
    end else begin
      rx_dv_oe_n <= 1'b0;
      case (lmode)
        PRF_GMII, PRF_TBI: begin
          rxd_oe_n <= `PRF_OE_ALL_ON;
          rx_er_oe_n <= 1'b0;
          if (load_ev) begin
            {rx_er_o, rx_dv_o, rxd_o} <= cur_next;
          end
        end
        PRF_MII10, PRF_MII100: begin
          rxd_oe_n <= `PRF_OE_LOW_ON;
          rx_er_oe_n <= 1'b0;
          rxd_o[`PRF_NIB_HI] <= 4'h0;
          if (rise_ev) begin
            rxd_o[`PRF_NIB_LO] <= cur_next[`PRF_NIB_LO];
            rx_dv_o <= cur_next[`PRF_W_DV];
            rx_er_o <= cur_next[`PRF_W_ER];
          end
        end
        PRF_RTBI: begin
          rxd_oe_n <= `PRF_OE_LOW_ON;
          rx_er_oe_n <= 1'b1;
          rx_er_o <= 1'b0;
          rxd_o[`PRF_NIB_HI] <= 4'h0;
          if (rise_ev) begin
            rxd_o[`PRF_NIB_LO] <= cur_next[`PRF_NIB_LO];
            rx_dv_o <= cur_next[`PRF_W_B4];
          end else if (fall_ev) begin
            rxd_o[`PRF_NIB_LO] <= cur_reg[`PRF_RTBI_HI];
            rx_dv_o <= cur_reg[`PRF_W_ER];
          end
        end
        default: begin
          rxd_oe_n <= `PRF_OE_LOW_ON;
          rx_er_oe_n <= 1'b1;
          rx_er_o <= 1'b0;
          rxd_o[`PRF_NIB_HI] <= 4'h0;
          if (rise_ev) begin
            rxd_o[`PRF_NIB_LO] <= cur_next[`PRF_NIB_LO];
            rx_dv_o <= cur_next[`PRF_W_DV];
          end else if (fall_ev) begin
            rx_dv_o <= cur_reg[`PRF_W_DV] ^ cur_reg[`PRF_W_ER];
            if (lmode == PRF_RGMII1000) begin
              rxd_o[`PRF_NIB_LO] <= cur_reg[`PRF_NIB_HI];
            end
          end
        end
      endcase
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (lrst_reg);

  sequence word_taken;
    load_ev && pend_valid_reg;
  endsequence

  sequence nibble_mode_seen;
    !$past(lrst_reg) && ($past(mii) || $past(rgmii));
  endsequence

  pins_released_a: assert property (
    $past(lrst_reg) |-> (&rxd_oe_n) && rx_dv_oe_n && rx_er_oe_n)
    else $error("pins driven while in reset");

  gmii_byte_a: assert property (
    (lmode == PRF_GMII) and word_taken |=> rxd_o == $past(pend_reg[`PRF_BYTE]) && !rxd_oe_n[7])
    else $error("gmii byte not launched");

  upper_hiz_a: assert property (
    nibble_mode_seen |-> rxd_oe_n[`PRF_NIB_HI] == 4'hF && rxd_oe_n[`PRF_NIB_LO] == 4'h0)
    else $error("upper data pins not floating");

  ddr_high_a: assert property (
    lmode == PRF_RGMII1000 && fall_ev |=> rxd_o[`PRF_NIB_LO] == $past(cur_reg[`PRF_NIB_HI]))
    else $error("high nibble missing on falling edge");

  tbi_group_a: assert property (
    (lmode == PRF_TBI) and word_taken |=> {rx_er_o, rx_dv_o, rxd_o} == $past(pend_reg))
    else $error("tbi group mapped wrongly");

  one_clock_a: assert property (
    !tbi2 ##1 !tbi2 |-> secondary_receive_clock_oe_n)
    else $error("secondary clock driven outside two-clock tbi");

  rtbi_fall_a: assert property (
    lmode == PRF_RTBI && fall_ev |=> rxd_o[`PRF_NIB_LO] == $past(cur_reg[`PRF_RTBI_HI])
      && rx_dv_o == $past(cur_reg[`PRF_W_ER]))
    else $error("rtbi falling half wrong");

  mii_rise_a: assert property (
    mii && rise_ev |=> rx_dv_o == $past(cur_next[`PRF_W_DV]) && rx_er_o == $past(cur_next[`PRF_W_ER]))
    else $error("mii valid or error not updated");

  rgmii_ctl_a: assert property (
    rgmii && fall_ev |=> rx_dv_o == ($past(cur_reg[`PRF_W_DV]) ^ $past(cur_reg[`PRF_W_ER])))
    else $error("rgmii control falling value wrong");

  err_hiz_a: assert property (
    !$past(lrst_reg) && $past(er_hiz_mode) |-> rx_er_oe_n)
    else $error("error pin driven in rgmii or rtbi");

  clock_phase_a: assert property (
    tbi2 && half_tick |=> secondary_receive_clock == !rx_clk_o)
    else $error("tbi clocks not in antiphase");

  clk_dir_a: assert property (
    ext_clk ##1 ext_clk |-> rx_clk_oe_n)
    else $error("receive clock driven while an input");

  // link cycles since the last half tick, counted apart from the divider so the DIV_100 setting is checked in RGMII100 mode
  logic [5:0] gap_reg;
  always_ff @(posedge link_clk) begin
    gap_reg <= (lrst_reg || half_tick) ? 6'h00 : gap_reg + 6'h01;
  end
  rate_100_a: assert property (
    lmode == PRF_RGMII100 && !ext_clk && half_tick |-> gap_reg == DIV_100 - 6'h01)
    else $error("100 mbps half period wrong");

endmodule // prf_rx_formatter

//--- src/prf_regs.svh
// shared constants and field positions of the receive pin formatter
`ifndef PRF_REGS_SVH
`define PRF_REGS_SVH
`define PRF_WORD_W 10
`define PRF_BUF_DEPTH 2
`define PRF_IDLE_WORD 10'h000
`define PRF_W_DV 8
`define PRF_W_ER 9
`define PRF_W_B4 4
`define PRF_NIB_LO 3:0
`define PRF_NIB_HI 7:4
`define PRF_RTBI_HI 8:5
`define PRF_BYTE 7:0
`define PRF_OE_ALL_OFF 8'hFF
`define PRF_OE_ALL_ON 8'h00
`define PRF_OE_LOW_ON 8'hF0
`define PRF_DIV_1000 6'h01
`define PRF_DIV_100 6'h05
`define PRF_DIV_10 6'h32
`define PRF_CFG_MODE 2:0
`define PRF_CFG_TWO 3
`define PRF_CFG_DIR 4
`endif

//--- src/prf_pkg.sv
// types of the receive pin formatter
`include "prf_regs.svh"
package prf_pkg;
  typedef enum logic [2:0] {
    PRF_GMII,
    PRF_MII10,
    PRF_MII100,
    PRF_RGMII10,
    PRF_RGMII100,
    PRF_RGMII1000,
    PRF_TBI,
    PRF_RTBI
  } prf_mode_t;
  typedef logic [`PRF_WORD_W-1:0] prf_word_t;
endpackage

//--- src/prf_buf.sv
// two-entry flip-flop buffer with valid and ready on both sides
`timescale 1ns/100ps
module prf_buf #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic ready_reg;
  logic push;
  logic pop;

  assign push = in_valid && ready_reg;
  assign pop = out_valid && out_ready;
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign in_ready = ready_reg;

  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      ready_reg <= 1'b0;
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
      // registered ready: a full buffer refuses the very next offer
      ready_reg <= cnt_next < (AW+1)'(DEPTH);
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule // prf_buf

//--- testbench/prf_mac_model.sv
// far-side receiver model: samples the receive pins on link clock edges and rebuilds words
`timescale 1ns/100ps
module prf_mac_model
  import prf_pkg::*;
(
  input wire logic link_clk,
  input wire prf_mode_t mode,
  input wire logic ext_clk_en,
  input wire logic [7:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic rx_clk,
  input wire logic sec_clk,
  output logic ext_clk,
  output logic got_v,
  output prf_word_t got_w
);
  logic clk_prev = 1'b0;
  logic sec_prev = 1'b0;
  logic ctl_r = 1'b0;
  logic [3:0] lo = 4'h0;
  logic [2:0] div = 3'h0;
  logic ddr;
  assign ddr = mode inside {PRF_RGMII10, PRF_RGMII100, PRF_RGMII1000, PRF_RTBI};
  initial begin
    ext_clk = 1'b0;
    got_v = 1'b0;
    got_w = '0;
  end
  always @(posedge link_clk) begin
    got_v <= 1'b0;
    clk_prev <= rx_clk;
    sec_prev <= sec_clk;
    div <= div + 3'h1;
    // clock supplied only while we own it; it stands still otherwise
    if (ext_clk_en && div == 3'h7) ext_clk <= ~ext_clk;
    if ((rx_clk && !clk_prev) || (sec_clk && !sec_prev)) begin
      lo <= rxd[3:0];
      ctl_r <= rx_dv;
      if (!ddr && rx_dv) begin
        got_v <= 1'b1;
        got_w <= {rx_er, rx_dv, rxd};
      end
    end else if (ddr && !rx_clk && clk_prev && ctl_r) begin
      got_v <= 1'b1;
      ctl_r <= 1'b0;
      if (mode == PRF_RTBI) got_w <= {rx_dv, rxd[3:0], ctl_r, lo};
      else got_w <= {ctl_r ^ rx_dv, ctl_r, rxd[3:0], lo};
    end
  end
endmodule // prf_mac_model

//--- testbench/tb_top.sv
// self-checking bench: per-mode pin formats, straps, pin enables and word order
`timescale 1ns/100ps
module tb_top
  import prf_pkg::*;
;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  prf_mode_t mode = PRF_GMII;
  logic tbi_two_clock_select = 1'b0;
  logic clock_direction_select = 1'b0;
  prf_word_t in_data = '0;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [7:0] rxd_o;
  logic [7:0] rxd_oe_n;
  logic [7:0] strap_rxd = 8'h00;
  logic strap_dv = 1'b0;
  logic strap_er = 1'b0;
  logic rx_dv_o, rx_dv_oe_n, rx_er_o, rx_er_oe_n, rx_clk_o, rx_clk_oe_n, sec_clk, sec_oe_n;
  logic ext_clk, got_v;
  prf_word_t got_w, strap_cfg;
  logic [7:0] rxd_w;
  logic dv_w, er_w;
  logic [9:0] cur_mask = 10'h3FF;
  prf_word_t exp_q[$];
  int seed = 69417;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  always #7.5 link_clk = ~link_clk;
  // pin level: strap while the device floats the pin, device value otherwise
  assign rxd_w = (rxd_oe_n & strap_rxd) | (~rxd_oe_n & rxd_o);
  assign dv_w = rx_dv_oe_n ? strap_dv : rx_dv_o;
  assign er_w = rx_er_oe_n ? strap_er : rx_er_o;
  prf_rx_formatter #(.DIV_10(6'h04), .DIV_100(6'h02)) DUT (.clk(clk), .rst(rst), .link_clk(link_clk),
    .mode(mode), .tbi_two_clock_select(tbi_two_clock_select), .clock_direction_select(clock_direction_select),
    .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready), .rxd_i(rxd_w), .rxd_o(rxd_o),
    .rxd_oe_n(rxd_oe_n), .rx_dv_i(dv_w), .rx_dv_o(rx_dv_o), .rx_dv_oe_n(rx_dv_oe_n), .rx_er_i(er_w),
    .rx_er_o(rx_er_o), .rx_er_oe_n(rx_er_oe_n), .rx_clk_i(ext_clk), .rx_clk_o(rx_clk_o),
    .rx_clk_oe_n(rx_clk_oe_n), .secondary_receive_clock(sec_clk), .secondary_receive_clock_oe_n(sec_oe_n),
    .strap_cfg(strap_cfg));
  prf_mac_model mac (.link_clk(link_clk), .mode(mode), .ext_clk_en(clock_direction_select), .rxd(rxd_w),
    .rx_dv(dv_w), .rx_er(er_w), .rx_clk(rx_clk_oe_n ? ext_clk : rx_clk_o), .sec_clk(sec_clk & !sec_oe_n),
    .ext_clk(ext_clk), .got_v(got_v), .got_w(got_w));
  task automatic check(input string name, input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic run_case(input prf_mode_t m, input logic ts, input logic sdv, input logic ds,
      input logic [9:0] mk, input logic [7:0] eoe, input logic eer, input logic esec, input int nw);
    prf_word_t w;
    int n;
    rst <= 1'b1;
    mode <= m;
    tbi_two_clock_select <= ts;
    clock_direction_select <= ds;
    strap_rxd <= 8'($random(seed));
    strap_er <= 1'($random(seed));
    strap_dv <= sdv;
    cur_mask <= mk;
    repeat (8) @(posedge clk);
    check("oe_in_reset", {rxd_oe_n, rx_dv_oe_n, rx_er_oe_n}, 10'h3FF);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    check("strap", strap_cfg, {strap_er, strap_dv, strap_rxd});
    check("data_oe", {rxd_oe_n, rx_dv_oe_n, rx_er_oe_n}, {eoe, 1'b0, eer});
    check("clk_oe", {8'h00, rx_clk_oe_n, sec_oe_n}, {8'h00, ds, esec});
    for (int i = 0; i < nw; i++) begin
      w = prf_word_t'($random(seed));
      // a marker bit lets the far side tell words from idle slots
      if (m == PRF_RTBI) w[4] = 1'b1;
      else w[8] = 1'b1;
      in_data <= w;
      in_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (in_ready !== 1'b1 && n < 100);
      exp_q.push_back(w & mk);
    end
    in_valid <= 1'b0;
    n = 0;
    while (exp_q.size() > 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check("words_lost", 10'(exp_q.size()), 10'h000);
  endtask
  always @(posedge link_clk) begin
    if (got_v === 1'b1 && exp_q.size() == 0) begin
      check("spare_word", {9'h000, got_v}, 10'h000);
    end else if (got_v === 1'b1) begin
      check("pin_word", got_w & cur_mask, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    run_case(PRF_GMII, 1'b0, 1'b0, 1'b0, 10'h3FF, 8'h00, 1'b0, 1'b1, 8);
    run_case(PRF_MII10, 1'b0, 1'b0, 1'b0, 10'h30F, 8'hF0, 1'b0, 1'b1, 6);
    run_case(PRF_MII100, 1'b0, 1'b0, 1'b0, 10'h30F, 8'hF0, 1'b0, 1'b1, 6);
    run_case(PRF_RGMII10, 1'b0, 1'b0, 1'b0, 10'h30F, 8'hF0, 1'b1, 1'b1, 6);
    run_case(PRF_RGMII100, 1'b0, 1'b0, 1'b0, 10'h30F, 8'hF0, 1'b1, 1'b1, 6);
    run_case(PRF_RGMII1000, 1'b0, 1'b0, 1'b0, 10'h3FF, 8'hF0, 1'b1, 1'b1, 10);
    run_case(PRF_TBI, 1'b1, 1'b0, 1'b0, 10'h3FF, 8'h00, 1'b0, 1'b0, 10);
    run_case(PRF_TBI, 1'b0, 1'b1, 1'b0, 10'h3FF, 8'h00, 1'b0, 1'b0, 10);
    run_case(PRF_TBI, 1'b0, 1'b0, 1'b0, 10'h3FF, 8'h00, 1'b0, 1'b1, 10);
    run_case(PRF_RTBI, 1'b0, 1'b0, 1'b0, 10'h3FF, 8'hF0, 1'b1, 1'b1, 10);
    run_case(PRF_MII100, 1'b0, 1'b0, 1'b1, 10'h30F, 8'hF0, 1'b0, 1'b1, 6);
    wrap_up();
  end
endmodule // tb_top
